// *** inc/sbpu_pkg.sv ***
// Constants and command codes of the status and block protection unit
package sbpu_pkg;
	// Command codes as decoded by the serial front end
	typedef enum logic [3:0] {
		SBPU_READ_STATUS,
		SBPU_WRITE_STATUS,
		SBPU_WRITE_ENABLE,
		SBPU_WRITE_DISABLE,
		SBPU_PAGE_PROGRAM,
		SBPU_ERASE_4K,
		SBPU_ERASE_32K,
		SBPU_ERASE_64K,
		SBPU_BULK_ERASE
	} sbpu_op_t;

	// Status byte field positions
	localparam int SBPU_BIT_BUSY = 0;
	localparam int SBPU_BIT_WEL = 1;
	localparam int SBPU_BIT_LVL_LO = 2;
	localparam int SBPU_BIT_TB = 5;
	localparam int SBPU_BIT_LVL3 = 6;
	localparam int SBPU_BIT_SRWD = 7;

	// Reset values of the nonvolatile and volatile bits
	localparam logic SBPU_RST_SRWD = 1'b1;
	localparam logic SBPU_RST_TB = 1'b1;
	localparam logic [3:0] SBPU_RST_LVL = 4'h0;
	localparam logic SBPU_RST_WEL = 1'b0;

	// Address layout: top byte 07FF FFFFh
	localparam int SBPU_ADDR_W = 27;
	localparam int SBPU_SEC_LSB = 16;
	localparam int SBPU_SUB32_LSB = 15;
	localparam int SBPU_SUB4_LSB = 12;
	localparam int SBPU_LVL_HALF = 11;
endpackage

// *** verilog/sbpu_status_protect.sv ***
// Status register and sector write protection of the serial flash
// Operation
// - Pages may be programmed singly; no page-sized erase command exists.
// - Addresses decode into 4KB, 32KB subsectors and 64KB sectors from zero.
// - Read-status returns the status byte; write-status updates it.
// - Bit 7 set with write-protect pin low makes nonvolatile bits read-only.
// - Hardware protection ends only when the write-protect pin goes high.
// - Bit 7 is status write disable, default 1.
// - Bit 5 selects top (0) or bottom (1) anchoring, default bottom.
// - Protect-level bits in 6 and 4:2 block program/erase of region.
// - Write-enable latch bit 1 clears at reset and gates every write.
// - Bit 0 reads 1 while a write, program or erase cycle runs.
// - Bulk erase runs only when all protect-level bits are zero.
// - Bit 0 always equals the inverse of the ready flag.
// - Level n protects 2^(n-1) sectors from top or bottom; 12+ all.
// - Protection holds against program and erase with the pin low.
// - A program or erase hitting a protected sector sets protection error.
`timescale 1ns/1ps
`default_nettype none
module sbpu_status_protect #(
	parameter int ADDR_W = sbpu_pkg::SBPU_ADDR_W
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Write-protect pin, low active
	input wire logic write_protect_n,
	// Decoded command from the serial front end
	input wire logic cmd_valid,
	input wire sbpu_pkg::sbpu_op_t cmd_op,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	// Array engine side
	input wire logic op_done,
	input wire logic clear_flags,
	output logic op_grant,
	output logic op_refuse,
	// Status outputs
	output logic [7:0] status_rd_data,
	output logic status_rd_valid,
	output logic busy,
	output logic ready_flag,
	output logic protect_error,
	// Address decode
	output logic [ADDR_W-17:0] sector_idx,
	output logic [ADDR_W-16:0] sub32_idx,
	output logic [ADDR_W-13:0] sub4_idx
);
	import sbpu_pkg::*;

	localparam int SEC_W = ADDR_W - SBPU_SEC_LSB;

	// Half-array level needs at least that many sector index bits
	if (SEC_W < SBPU_LVL_HALF) begin : g_bad_width
		$error("sbpu_status_protect: ADDR_W too small for protect levels");
	end

	// Index port widths assume a sector holds two 32KB and sixteen 4KB subsectors
	if (SBPU_SEC_LSB != SBPU_SUB32_LSB + 1 || SBPU_SEC_LSB != SBPU_SUB4_LSB + 4) begin : g_bad_layout
		$error("sbpu_status_protect: index ports do not fit the address layout");
	end

	typedef struct packed {
		logic srwd;
		logic tb;
		logic [3:0] lvl;
		logic wel;
		logic busy;
		logic perr;
		logic [7:0] rd_data;
		logic rd_valid;
		logic grant;
		logic refuse;
		logic [SEC_W-1:0] sector;
		logic [SEC_W:0] sub32;
		logic [SEC_W+3:0] sub4;
	} sbpu_state_t;

	sbpu_state_t state_r;
	sbpu_state_t state_nxt;
	logic hw_locked;
	logic [7:0] status_byte;
	logic [SEC_W-1:0] cmd_sector;
	logic target_prot;
	logic is_array_op;

	// Sector protection test; bounds kept one bit wider to hold the full count
	function automatic logic sector_prot(input logic [SEC_W-1:0] s, input logic tb,
			input logic [3:0] lvl);
		logic [SEC_W:0] cnt;
		logic [SEC_W:0] total;
		logic [SEC_W:0] sx;
		cnt = '0;
		total = '0;
		sx = {1'b0, s};
		total[SEC_W] = 1'b1;
		if (lvl == 4'h0) begin
			sector_prot = 1'b0;
		end else if (lvl > 4'(SBPU_LVL_HALF)) begin
			sector_prot = 1'b1;
		end else begin
			cnt = (SEC_W+1)'(1) << (lvl - 4'h1);
			sector_prot = tb ? (sx < cnt) : (sx >= total - cnt);
		end
	endfunction

	// Hardware lock is purely combinational so it lifts the moment the pin rises
	assign hw_locked = state_r.srwd & ~write_protect_n;
	assign status_byte = {state_r.srwd, state_r.lvl[3], state_r.tb, state_r.lvl[2:0],
		state_r.wel, state_r.busy};
	assign cmd_sector = cmd_addr[ADDR_W-1:SBPU_SEC_LSB];
	assign target_prot = sector_prot(cmd_sector, state_r.tb, state_r.lvl);
	// Page program is the only sub-sector write; there is no page erase
	assign is_array_op = (cmd_op == SBPU_PAGE_PROGRAM) || (cmd_op == SBPU_ERASE_4K) ||
		(cmd_op == SBPU_ERASE_32K) || (cmd_op == SBPU_ERASE_64K);

	// Next-state: clears first so a same-cycle set wins
	always_comb begin
		state_nxt = state_r;
		state_nxt.rd_valid = 1'b0;
		state_nxt.grant = 1'b0;
		state_nxt.refuse = 1'b0;
		if (op_done) begin
			state_nxt.busy = 1'b0;
		end
		if (clear_flags) begin
			state_nxt.perr = 1'b0;
		end
		if (cmd_valid) begin
			state_nxt.sector = cmd_addr[ADDR_W-1:SBPU_SEC_LSB];
			state_nxt.sub32 = cmd_addr[ADDR_W-1:SBPU_SUB32_LSB];
			state_nxt.sub4 = cmd_addr[ADDR_W-1:SBPU_SUB4_LSB];
			unique case (cmd_op)
				SBPU_READ_STATUS: begin
					state_nxt.rd_data = status_byte;
					state_nxt.rd_valid = 1'b1;
				end
				SBPU_WRITE_ENABLE: begin
					if (!state_r.busy) begin
						state_nxt.wel = 1'b1;
					end
				end
				SBPU_WRITE_DISABLE: begin
					if (!state_r.busy) begin
						state_nxt.wel = 1'b0;
					end
				end
				SBPU_WRITE_STATUS: begin
					if (!state_r.busy && state_r.wel && !hw_locked) begin
						state_nxt.srwd = cmd_data[SBPU_BIT_SRWD];
						state_nxt.tb = cmd_data[SBPU_BIT_TB];
						state_nxt.lvl = {cmd_data[SBPU_BIT_LVL3],
							cmd_data[SBPU_BIT_LVL_LO+2:SBPU_BIT_LVL_LO]};
						state_nxt.wel = 1'b0;
						state_nxt.busy = 1'b1;
						state_nxt.grant = 1'b1;
					end else begin
						state_nxt.refuse = 1'b1;
					end
				end
				SBPU_PAGE_PROGRAM, SBPU_ERASE_4K, SBPU_ERASE_32K, SBPU_ERASE_64K: begin
					if (!state_r.busy && state_r.wel && is_array_op) begin
						state_nxt.wel = 1'b0;
						if (target_prot) begin
							state_nxt.perr = 1'b1;
							state_nxt.refuse = 1'b1;
						end else begin
							state_nxt.busy = 1'b1;
							state_nxt.grant = 1'b1;
						end
					end else begin
						state_nxt.refuse = 1'b1;
					end
				end
				SBPU_BULK_ERASE: begin
					if (!state_r.busy && state_r.wel) begin
						state_nxt.wel = 1'b0;
						if (state_r.lvl != 4'h0) begin
							state_nxt.perr = 1'b1;
							state_nxt.refuse = 1'b1;
						end else begin
							state_nxt.busy = 1'b1;
							state_nxt.grant = 1'b1;
						end
					end else begin
						state_nxt.refuse = 1'b1;
					end
				end
				default: begin
					state_nxt.refuse = 1'b1;
				end
			endcase
		end
	end

	// State register; reset stands in for power-up defaults
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= '0;
			state_r.srwd <= SBPU_RST_SRWD;
			state_r.tb <= SBPU_RST_TB;
			state_r.lvl <= SBPU_RST_LVL;
			state_r.wel <= SBPU_RST_WEL;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// Outputs
	assign op_grant = state_r.grant;
	assign op_refuse = state_r.refuse;
	assign status_rd_data = state_r.rd_data;
	assign status_rd_valid = state_r.rd_valid;
	assign busy = state_r.busy;
	assign ready_flag = ~state_r.busy;
	assign protect_error = state_r.perr;
	assign sector_idx = state_r.sector;
	assign sub32_idx = state_r.sub32;
	assign sub4_idx = state_r.sub4;

	// Checks on the protection decisions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Lock, latch and protect-level gating of status and array writes
	wsr_hw_lock_a: assert property (clk_en && cmd_valid && cmd_op == SBPU_WRITE_STATUS &&
		state_r.srwd && !write_protect_n |=> !op_grant && op_refuse && $stable(state_r.lvl))
		else $error("status write accepted while hardware locked");
	wel_gate_a: assert property (clk_en && cmd_valid && !state_r.wel &&
		cmd_op != SBPU_READ_STATUS |=> !op_grant)
		else $error("write granted without write enable latch");
	bulk_block_a: assert property (clk_en && cmd_valid && cmd_op == SBPU_BULK_ERASE &&
		state_r.lvl != 4'h0 |=> !op_grant)
		else $error("bulk erase granted with protection set");
	prot_err_a: assert property (clk_en && cmd_valid && is_array_op && state_r.wel &&
		!state_r.busy && target_prot |=> protect_error && !busy && !op_grant)
		else $error("protected access not flagged or started");
	// A started cycle shows busy and drops ready in the same cycle
	grant_busy_a: assert property (op_grant |-> busy && !ready_flag)
		else $error("granted operation not busy");
	ready_inv_a: assert property (ready_flag != status_byte[SBPU_BIT_BUSY])
		else $error("busy bit not inverse of ready flag");
	// Read answers and address capture
	rd_status_a: assert property (clk_en && cmd_valid && cmd_op == SBPU_READ_STATUS |=>
		status_rd_valid && status_rd_data == $past(status_byte))
		else $error("read status returned wrong byte");
	decode_a: assert property (clk_en && cmd_valid |=>
		sector_idx == $past(cmd_addr[ADDR_W-1:SBPU_SEC_LSB]) &&
		sub4_idx[3:0] == $past(cmd_addr[SBPU_SEC_LSB-1:SBPU_SUB4_LSB]))
		else $error("address decode mismatch");
	// Level one from the top guards only the last sector
	top_sector_a: assert property (clk_en && cmd_valid && is_array_op &&
		state_r.wel && !state_r.busy && state_r.lvl == 4'h1 && !state_r.tb &&
		cmd_sector == {SEC_W{1'b1}} |=> op_refuse && protect_error)
		else $error("top sector not protected at level one");
	// Level one from the bottom guards only sector zero
	bottom_sector_a: assert property (clk_en && cmd_valid && is_array_op &&
		state_r.wel && !state_r.busy && state_r.lvl == 4'h1 && state_r.tb &&
		cmd_sector == '0 |=> op_refuse && protect_error)
		else $error("bottom sector not protected at level one");
	// Levels past the half-array step leave no sector open
	all_sectors_a: assert property (clk_en && cmd_valid && is_array_op &&
		state_r.wel && !state_r.busy && state_r.lvl > 4'(SBPU_LVL_HALF) |=> op_refuse && !op_grant)
		else $error("array access granted with every sector protected");
	// With no level bit set every enabled array access starts
	open_array_a: assert property (clk_en && cmd_valid && is_array_op &&
		state_r.wel && !state_r.busy && state_r.lvl == 4'h0 |=> op_grant && busy)
		else $error("unprotected array access not started");
	// A refused protected access must not start the engine
	prot_idle_a: assert property (clk_en && cmd_valid && is_array_op && target_prot |=>
		!op_grant)
		else $error("protected access started a cycle");
	// Bulk erase goes ahead once every level bit is clear
	bulk_open_a: assert property (clk_en && cmd_valid && cmd_op == SBPU_BULK_ERASE &&
		state_r.wel && !state_r.busy && state_r.lvl == 4'h0 |=> op_grant)
		else $error("bulk erase refused with no protection");
	// With the pin high the status write goes through whatever bit 7 holds
	lock_lift_a: assert property (clk_en && cmd_valid && cmd_op == SBPU_WRITE_STATUS &&
		write_protect_n && state_r.wel && !state_r.busy |=> op_grant)
		else $error("status write refused with pin high");
	// Every started cycle spends the write enable latch
	wel_spent_a: assert property (op_grant |-> !status_byte[SBPU_BIT_WEL])
		else $error("write enable latch kept after grant");
	// Busy holds until the engine reports completion
	busy_hold_a: assert property (clk_en && busy && !op_done |=> busy)
		else $error("busy dropped before completion");
	// The busy bit of a read answer is the inverse of the ready flag it was read with
	rd_busy_a: assert property (status_rd_valid |->
		status_rd_data[SBPU_BIT_BUSY] != $past(ready_flag))
		else $error("read busy bit disagrees with ready flag");
	// A low enable freezes every bit of state, pulses included
	freeze_a: assert property (!clk_en |=> $stable(state_r))
		else $error("state changed while clock enable low");

	// Main scenarios; the bench reaches all but a granted page program
	grant_prog_c: cover property (cmd_valid && cmd_op == SBPU_PAGE_PROGRAM ##1 op_grant);
	perr_set_c: cover property ($rose(protect_error));
	hw_refuse_c: cover property (hw_locked && cmd_valid && cmd_op == SBPU_WRITE_STATUS ##1 op_refuse);
	bulk_grant_c: cover property (cmd_valid && cmd_op == SBPU_BULK_ERASE ##1 op_grant);
	freeze_c: cover property (!clk_en && cmd_valid);
endmodule // sbpu_status_protect
`default_nettype wire

// *** test/sbpu_engine_model.sv ***
// Array engine model that finishes each granted cycle after a delay
`timescale 1ns/1ps
`default_nettype none
module sbpu_engine_model #(
	parameter int DELAY = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Handshake with the unit
	input wire logic op_grant,
	output logic op_done
);
	int count_r;
	// Restart the count on every grant so a stray grant is never lost
	always_ff @(posedge clk) begin
		if (reset) begin
			count_r <= 0;
			op_done <= 1'b0;
		end else begin
			op_done <= (count_r == 1);
			if (op_grant)
				count_r <= DELAY;
			else if (count_r != 0)
				count_r <= count_r - 1;
		end
	end
endmodule // sbpu_engine_model
`default_nettype wire

// *** test/sbpu_status_protect_test.sv ***
// Command sequences with expected answers for the protection unit
`timescale 1ns/1ps
`default_nettype none
module sbpu_status_protect_test;
	import sbpu_pkg::*;
	// Stimulus, all driven on the rising edge
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic write_protect_n = 1'b1;
	logic cmd_valid = 1'b0;
	sbpu_op_t cmd_op = SBPU_READ_STATUS;
	logic [26:0] cmd_addr = 27'h0;
	logic [7:0] cmd_data = 8'h00;
	logic clear_flags = 1'b0;
	logic clk_en = 1'b1;
	logic op_done, op_grant, op_refuse, rd_valid, busy, ready_flag, protect_error;
	logic [7:0] rd_data;
	logic [10:0] sector_idx;
	logic [14:0] sub4_idx;
	logic [11:0] sub32_idx;
	int bad_count = 0;
	int checks_done = 0;
	always #4 clk = ~clk;
	sbpu_status_protect sbpu_status_protect_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
		.write_protect_n(write_protect_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .op_done(op_done), .clear_flags(clear_flags),
		.op_grant(op_grant), .op_refuse(op_refuse), .status_rd_data(rd_data),
		.status_rd_valid(rd_valid), .busy(busy), .ready_flag(ready_flag),
		.protect_error(protect_error), .sector_idx(sector_idx), .sub32_idx(sub32_idx),
		.sub4_idx(sub4_idx));
	sbpu_engine_model sbpu_engine_model_inst (.clk(clk), .reset(reset), .op_grant(op_grant),
		.op_done(op_done));
	task automatic test_done();
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	// One-cycle command; its answer is registered at the taking edge
	task automatic issue(sbpu_op_t op, logic [26:0] addr, logic [7:0] data);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= addr;
		cmd_data <= data;
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1;
	endtask
	task automatic wr(sbpu_op_t op, logic [26:0] addr, logic [7:0] data, logic [1:0] exp);
		issue(op, addr, data);
		check("grant_refuse", 16'(exp), {14'h0, op_grant, op_refuse});
	endtask
	task automatic rd(logic [7:0] exp);
		issue(SBPU_READ_STATUS, 27'h0, 8'h00);
		check("status", {8'h01, exp}, {7'h0, rd_valid, rd_data});
	endtask
	// Bounded wait for the running cycle to finish
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		#1;
		check("busy_idle", 16'h0, 16'(busy));
		if (busy !== 1'b0)
			test_done();
	endtask
	// Write enable first, as the host must, then the status write
	task automatic set_status(logic [7:0] v);
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		wr(SBPU_WRITE_STATUS, 27'h0, v, 2'b10);
		check("busy_ready", 16'h2, {14'h0, busy, ready_flag});
		wait_idle();
		rd(v);
	endtask
	initial begin
		logic [3:0] lvl;
		int sz, p, u;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(8'hA0);
		wr(SBPU_PAGE_PROGRAM, 27'h0, 8'h00, 2'b01);
		// A command offered while the enable is low must be lost
		@(posedge clk);
		clk_en <= 1'b0;
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(8'hA0);
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		rd(8'hA2);
		@(posedge clk);
		write_protect_n <= 1'b0;
		wr(SBPU_WRITE_STATUS, 27'h0, 8'h00, 2'b01);
		rd(8'hA2);
		@(posedge clk);
		write_protect_n <= 1'b1;
		set_status(8'h00);
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		issue(SBPU_WRITE_DISABLE, 27'h0, 8'h00);
		wr(SBPU_PAGE_PROGRAM, 27'h0, 8'h00, 2'b01);
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		wr(SBPU_ERASE_4K, 27'h7FFF000, 8'h00, 2'b10);
		check("sub4", 16'h7FFF, 16'(sub4_idx));
		check("sub32", 16'h0FFF, 16'(sub32_idx));
		check("sector", 16'h07FF, 16'(sector_idx));
		wait_idle();
		// Each level 1 to 11 from both ends: last protected and first free sector
		for (int t = 0; t < 2; t++) begin
			for (int n = 1; n < 12; n++) begin
				lvl = 4'(n);
				sz = 1 << (n - 1);
				p = t ? sz - 1 : 2048 - sz;
				u = t ? sz : 2047 - sz;
				set_status({1'b0, lvl[3], t[0], lvl[2:0], 2'b00});
				issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
				wr(t ? SBPU_ERASE_64K : SBPU_PAGE_PROGRAM, 27'(p << 16), 8'h00, 2'b01);
				check("perr_busy", 16'h2, {14'h0, protect_error, busy});
				issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
				wr(SBPU_ERASE_32K, 27'(u << 16), 8'h00, 2'b10);
				check("sector", 16'(u), 16'(sector_idx));
				check("sub32", 16'(u << 1), 16'(sub32_idx));
				wait_idle();
			end
		end
		// Level twelve from the top closes the whole array
		set_status(8'h50);
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		wr(SBPU_ERASE_4K, 27'h4000000, 8'h00, 2'b01);
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		wr(SBPU_BULK_ERASE, 27'h0, 8'h00, 2'b01);
		set_status(8'h20);
		@(posedge clk);
		clear_flags <= 1'b1;
		@(posedge clk);
		clear_flags <= 1'b0;
		issue(SBPU_WRITE_ENABLE, 27'h0, 8'h00);
		wr(SBPU_BULK_ERASE, 27'h0, 8'h00, 2'b10);
		check("perr_clear", 16'h0, 16'(protect_error));
		wait_idle();
		// A second reset mid-run must bring the nonvolatile defaults back
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(8'hA0);
		check("ready_flag", 16'h1, 16'(ready_flag));
		test_done();
	end
endmodule // sbpu_status_protect_test
`default_nettype wire
